// ==== test/ats_pwm_model.sv ====
// Model of the PWM generator and analog core that face the sequencer.
`timescale 1ns/1ns
module ats_pwm_model
	import ats_pkg::*;
(
	// Clock and conversion state
	input wire logic clk_i,
	input wire logic busy_i,
	// Event flags and converted value
	output logic period_flag_o,
	output logic [2:0] duty_flag_o,
	output logic [11:0] result_o
);
	logic [11:0] value = 12'h000;
	initial
	begin
		period_flag_o = 1'b0;
		duty_flag_o = 3'h0;
	end
	// Outside a conversion the value is inverted so a stray sample shows up.
	assign result_o = busy_i ? value : ~value;
	// Channel 3 is the period-match flag; each flag stays up for four clocks.
	task automatic fire(input int ch);
		@(posedge clk_i);
		if (ch == 3)
			period_flag_o <= 1'b1;
		else
			duty_flag_o[ch] <= 1'b1;
		repeat (4) @(posedge clk_i);
		period_flag_o <= 1'b0;
		duty_flag_o <= 3'h0;
	endtask : fire
endmodule : ats_pwm_model

// ==== test/testbench.sv ====
// Self-checking testbench for the A/D trigger sequencer.
`timescale 1ns/1ns
module testbench;
	import ats_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, per_flag, pwr_en, sample, busy, adc_irq, cmp_irq;
	logic [2:0] duty_flag;
	logic [11:0] result;
	int n_mismatch = 0;
	int checked = 0;
	always #4 clk = ~clk;
	ats_trigger_sequencer DUT (.CLOCK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.PWM_PERIOD_FLAG_I(per_flag), .PWM_DUTY_FLAG_I(duty_flag), .RESULT_I(result),
		.POWER_EN_O(pwr_en), .SAMPLE_O(sample), .BUSY_O(busy), .ADC_IRQ_O(adc_irq),
		.CMP_IRQ_O(cmp_irq));
	ats_pwm_model pwm (.clk_i(clk), .busy_i(busy), .period_flag_o(per_flag),
		.duty_flag_o(duty_flag), .result_o(result));
	task automatic conclude;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, {24'h0, d}, q, e);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(what, {24'h0, exp}, q);
	endtask : rd_chk
	// Counts clocks to the busy rise, then busy and sampling clocks.
	task automatic run_len(output int rise, output int len, output int smp);
		rise = 0;
		len = 0;
		smp = 0;
		while (busy !== 1'b1 && rise < 300)
		begin
			@(posedge clk);
			#1;
			rise++;
		end
		while (busy === 1'b1 && len < 3000)
		begin
			smp += (sample === 1'b1);
			@(posedge clk);
			#1;
			len++;
		end
	endtask : run_len
	task automatic soft_conv(input logic [7:0] c0, output int len, output int smp);
		int r;
		wr(OFF_CTRL0, c0 | 8'h01);
		@(negedge clk);
		chk("busy before pulse ends", 32'h0, {31'h0, busy});
		wr(OFF_CTRL0, c0);
		run_len(r, len, smp);
	endtask : soft_conv
	task automatic t_regs;
		logic [31:0] q;
		logic e;
		rd_chk(OFF_DELAY, DELAY_RST, "delay reset");
		wr(OFF_DELAY, 8'ha5);
		rd_chk(OFF_DELAY, 8'ha5, "delay rw");
		wr(OFF_CTRL2, 8'h7f);
		rd_chk(OFF_CTRL2, 8'h7b, "ctrl2 bit 2");
		apb(1'b0, 8'h30, 32'h0, q, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		wr(OFF_CTRL2, 8'h00);
		wr(OFF_DELAY, 8'h00);
	endtask : t_regs
	task automatic t_soft;
		int l, s;
		wr(OFF_IRQ_EN, 8'h03);
		wr(OFF_CTRL0, 8'h04);
		repeat (20) @(posedge clk);
		@(negedge clk);
		chk("power enable", 32'h1, {31'h0, pwr_en});
		for (int n = 0; n < 3; n++)
		begin
			wr(OFF_CTRL1, 8'(n));
			soft_conv(8'h04, l, s);
			chk("busy length", 32'(16 << n), 32'(l));
			chk("sample length", 32'(4 << n), 32'(s));
			repeat (2) @(negedge clk);
			chk("done irq", 32'h1, {31'h0, adc_irq});
			wr(OFF_FLAGS, 8'h03);
		end
		wr(OFF_IRQ_EN, 8'h02);
		wr(OFF_CTRL1, 8'h06);
		soft_conv(8'h04, l, s);
		chk("busy length code 6", 32'd1024, 32'(l));
		chk("sample length code 6", 32'd256, 32'(s));
		repeat (2) @(negedge clk);
		chk("done irq masked", 32'h0, {31'h0, adc_irq});
		rd_chk(OFF_FLAGS, 8'h01, "done flag");
		wr(OFF_FLAGS, 8'h03);
		wr(OFF_CTRL1, 8'h00);
	endtask : t_soft
	task automatic t_pwm;
		int r0, r5, l, s;
		wr(OFF_CTRL0, 8'h0d);
		wr(OFF_CTRL0, 8'h0c);
		pwm.fire(0);
		@(negedge clk);
		chk("start or duty in period mode", 32'h0, {31'h0, busy});
		fork
			pwm.fire(3);
			run_len(r0, l, s);
		join
		chk("period trigger", 32'd16, 32'(l));
		wr(OFF_CTRL2, 8'h40);
		wr(OFF_DELAY, 8'h05);
		fork
			pwm.fire(3);
			run_len(r5, l, s);
		join
		chk("delay clocks", 32'd5, 32'(r5 - r0));
		wr(OFF_CTRL2, 8'h00);
		wr(OFF_DELAY, 8'h00);
	endtask : t_pwm
	task automatic t_duty;
		int r, l, s, c;
		for (int k = 0; k < 4; k++)
		begin
			c = (k == 3) ? 2 : k;
			wr(OFF_CTRL2, 8'(32 + k));
			pwm.fire((c + 1) % 3);
			@(negedge clk);
			chk("other duty channel", 32'h0, {31'h0, busy});
			fork
				pwm.fire(c);
				run_len(r, l, s);
			join
			chk("selected duty channel", 32'd16, 32'(l));
		end
	endtask : t_duty
	task automatic t_bound;
		int l, s;
		logic [11:0] v [3] = '{12'h200, 12'h123, 12'h456};
		logic lo, hi, e;
		wr(OFF_CTRL0, 8'h04);
		wr(OFF_LB_HI, 8'h12);
		wr(OFF_LB_LO, 8'h30);
		wr(OFF_CTRL0, 8'h14);
		wr(OFF_HB_HI, 8'h04);
		wr(OFF_HB_LO, 8'h56);
		rd_chk(OFF_LB_HI, 8'h01, "low bound high byte");
		rd_chk(OFF_LB_LO, 8'h23, "low bound low byte");
		for (int c = 0; c < 4; c++)
			for (int i = 0; i < 3; i++)
			begin
				wr(OFF_CTRL2, 8'(c << 3));
				pwm.value <= v[i];
				soft_conv(8'h14, l, s);
				lo = v[i] <= 12'h123;
				hi = v[i] >= 12'h456;
				e = (c == 0) ? !lo && !hi : (c == 1) ? lo : (c == 2) ? hi : lo | hi;
				repeat (2) @(negedge clk);
				chk("compare irq", {31'h0, e}, {31'h0, cmp_irq});
				wr(OFF_FLAGS, 8'h03);
			end
		rd_chk(OFF_RES_HI, 8'h04, "result high byte");
		rd_chk(OFF_RES_LO, 8'h56, "result low byte");
		wr(OFF_CTRL0, 8'h00);
		rd_chk(OFF_HB_HI, 8'h45, "high bound high byte off");
		rd_chk(OFF_HB_LO, 8'h60, "high bound low byte off");
		chk("power enable off", 32'h0, {31'h0, pwr_en});
	endtask : t_bound
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_soft();
		t_pwm();
		t_duty();
		t_bound();
		conclude();
	end
	initial
	begin
		#400000;
		n_mismatch++;
		conclude();
	end
endmodule : testbench

// ==== verilog/ats_pkg.sv ====
// Package of offsets, field positions, reset values and types for the A/D trigger sequencer.
package ats_pkg;
	localparam logic [7:0] OFF_CTRL0 = 8'h00;
	localparam logic [7:0] OFF_CTRL1 = 8'h04;
	localparam logic [7:0] OFF_CTRL2 = 8'h08;
	localparam logic [7:0] OFF_DELAY = 8'h0c;
	localparam logic [7:0] OFF_LB_HI = 8'h10;
	localparam logic [7:0] OFF_LB_LO = 8'h14;
	localparam logic [7:0] OFF_HB_HI = 8'h18;
	localparam logic [7:0] OFF_HB_LO = 8'h1c;
	localparam logic [7:0] OFF_RES_HI = 8'h20;
	localparam logic [7:0] OFF_RES_LO = 8'h24;
	localparam logic [7:0] OFF_FLAGS = 8'h28;
	localparam logic [7:0] OFF_IRQ_EN = 8'h2c;
	localparam int START_BIT = 0;
	localparam int BUSY_BIT = 1;
	localparam int PWR_BIT = 2;
	localparam int TSRC_BIT = 3;
	localparam int FMT_BIT = 4;
	localparam int DONE_BIT = 0;
	localparam int CMP_BIT = 1;
	localparam logic [7:0] DELAY_RST = 8'h00;
	localparam logic [2:0] DIV_RST = 3'h0;
	localparam logic [11:0] BOUND_RST = 12'h000;
	localparam logic [6:0] PRESC_ONES = 7'h7f;
	localparam logic [3:0] SAMPLE_TICKS = 4'h4;
	localparam logic [4:0] CONVERT_TICKS = 5'h0c;
	localparam logic [4:0] TOTAL_TICKS = 5'(SAMPLE_TICKS) + CONVERT_TICKS;
	localparam logic [1:0] CMP_INSIDE = 2'h0;
	localparam logic [1:0] CMP_AT_LOW = 2'h1;
	localparam logic [1:0] CMP_AT_HIGH = 2'h2;
	typedef struct packed {
		logic delay_enable;
		logic pwm_event_select;
		logic [1:0] compare_condition_select;
		logic unused_zero;
		logic [1:0] duty_source_select;
	} ats_ctrl2_t;
	localparam ats_ctrl2_t CTRL2_RST = 7'h00;
	typedef enum {ST_IDLE, ST_SAMPLE, ST_CONVERT} ats_state_t;
endpackage : ats_pkg

// ==== verilog/ats_trigger_sequencer.sv ====
// A/D converter trigger, delay, timing, boundary compare and APB register block.
//
// Behaviour
// - Duty selector 00, 01, 1x picks PWM duty channel 0, 1, 2.
// - Bit 2 of control register 2 always reads zero.
// - Eight-bit delay register, read/write, resets to zero, counts system clocks.
// - Delay counting starts on a rising edge of the selected PWM flag.
// - High and low 12-bit boundary values are compared with the result.
// - Boundary values keep their contents while the converter is powered off.
// - Format 0: high byte holds bits 11..4, low byte upper nibble bits 3..0.
// - Format 1: high byte low nibble bits 11..8, low byte bits 7..0.
// - Trigger source bit picks software start or PWM event.
// - Software drives start low, high, low; one conversion follows.
// - PWM event bit picks period match or selected duty match.
// - Delay enable inserts programmed delay; otherwise the start is immediate.
// - Busy flag sets once a conversion is initiated.
// - Busy flag clears when the conversion cycle ends.
// - Completion sets the request flag; interrupt forwarded only when enabled.
// - A/D clock comes from the system clock, direct or divided, by three bits.
// - Conversion takes 4 sampling plus 12 converting A/D clocks, 16 total.
// - Compare condition: inside bounds, at or below low, at or above high, either.
`timescale 1ns/1ns
module ats_trigger_sequencer
	import ats_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// PWM events and converter data
	input wire logic PWM_PERIOD_FLAG_I,
	input wire logic [2:0] PWM_DUTY_FLAG_I,
	input wire logic [11:0] RESULT_I,
	// Converter control and interrupts
	output logic POWER_EN_O,
	output logic SAMPLE_O,
	output logic BUSY_O,
	output logic ADC_IRQ_O,
	output logic CMP_IRQ_O
);
	// Byte view of a 12-bit value in either justification.
	function automatic logic [7:0] byte_view(input logic [11:0] v, input logic fmt,
		input logic hi);
		if (!fmt)
		begin
			byte_view = hi ? v[11:4] : {v[3:0], 4'h0};
		end
		else
		begin
			byte_view = hi ? {4'h0, v[11:8]} : v[7:0];
		end
	endfunction : byte_view

	// Merges a written byte into a 12-bit value in either justification.
	function automatic logic [11:0] byte_merge(input logic [11:0] v, input logic fmt,
		input logic hi, input logic [7:0] d);
		if (!fmt)
		begin
			byte_merge = hi ? {d, v[3:0]} : {v[11:4], d[7:4]};
		end
		else
		begin
			byte_merge = hi ? {d[3:0], v[7:0]} : {v[11:8], d};
		end
	endfunction : byte_merge

	logic start_reg;
	logic start_prev_reg;
	logic power_reg;
	logic tsrc_reg;
	logic fmt_reg;
	logic [2:0] div_reg;
	ats_ctrl2_t ctrl2_reg;
	logic [7:0] delay_reg;
	logic [11:0] low_bound_reg;
	logic [11:0] high_bound_reg;
	logic [11:0] result_reg;
	logic done_flag_reg;
	logic cmp_flag_reg;
	logic [1:0] irq_en_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic pwm_prev_reg;
	logic dly_active_reg;
	logic [7:0] dly_cnt_reg;
	logic [6:0] presc_reg;
	logic [4:0] tick_cnt_reg;
	ats_state_t state_reg;
	ats_state_t state_next;
	logic busy_reg;
	logic sample_reg;
	logic adc_irq_reg;
	logic cmp_irq_reg;

	// Bus decode.
	wire access = PSEL_I && PENABLE_I;
	wire wr = access && PWRITE_I && pready_reg;
	wire wr_ctrl0 = wr && (PADDR_I == OFF_CTRL0);
	wire wr_ctrl1 = wr && (PADDR_I == OFF_CTRL1);
	wire wr_ctrl2 = wr && (PADDR_I == OFF_CTRL2);
	wire wr_delay = wr && (PADDR_I == OFF_DELAY);
	wire wr_lb_hi = wr && (PADDR_I == OFF_LB_HI);
	wire wr_lb_lo = wr && (PADDR_I == OFF_LB_LO);
	wire wr_hb_hi = wr && (PADDR_I == OFF_HB_HI);
	wire wr_hb_lo = wr && (PADDR_I == OFF_HB_LO);
	wire wr_flags = wr && (PADDR_I == OFF_FLAGS);
	wire wr_irq_en = wr && (PADDR_I == OFF_IRQ_EN);
	logic [7:0] rd_byte;
	logic addr_ok;

	always_comb
	begin
		addr_ok = 1'b1;
		if (PADDR_I == OFF_CTRL0)
			rd_byte = {3'h0, fmt_reg, tsrc_reg, power_reg, busy_reg, start_reg};
		else if (PADDR_I == OFF_CTRL1)
			rd_byte = {5'h00, div_reg};
		else if (PADDR_I == OFF_CTRL2)
			rd_byte = {1'b0, ctrl2_reg[6:3], 1'b0, ctrl2_reg[1:0]};
		else if (PADDR_I == OFF_DELAY)
			rd_byte = delay_reg;
		else if (PADDR_I == OFF_LB_HI)
			rd_byte = byte_view(low_bound_reg, fmt_reg, 1'b1);
		else if (PADDR_I == OFF_LB_LO)
			rd_byte = byte_view(low_bound_reg, fmt_reg, 1'b0);
		else if (PADDR_I == OFF_HB_HI)
			rd_byte = byte_view(high_bound_reg, fmt_reg, 1'b1);
		else if (PADDR_I == OFF_HB_LO)
			rd_byte = byte_view(high_bound_reg, fmt_reg, 1'b0);
		else if (PADDR_I == OFF_RES_HI)
			rd_byte = byte_view(result_reg, fmt_reg, 1'b1);
		else if (PADDR_I == OFF_RES_LO)
			rd_byte = byte_view(result_reg, fmt_reg, 1'b0);
		else if (PADDR_I == OFF_FLAGS)
			rd_byte = {6'h00, cmp_flag_reg, done_flag_reg};
		else if (PADDR_I == OFF_IRQ_EN)
			rd_byte = {6'h00, irq_en_reg};
		else
		begin
			rd_byte = 8'h00;
			addr_ok = 1'b0;
		end
	end

	// Trigger selection and delay counter.
	wire duty_flag = ctrl2_reg.duty_source_select[1] ? PWM_DUTY_FLAG_I[2] :
		PWM_DUTY_FLAG_I[ctrl2_reg.duty_source_select[0]];
	wire pwm_flag = ctrl2_reg.pwm_event_select ? duty_flag : PWM_PERIOD_FLAG_I;
	wire pwm_edge = tsrc_reg && pwm_flag && !pwm_prev_reg;
	wire use_delay = ctrl2_reg.delay_enable && (delay_reg != DELAY_RST);
	wire dly_hit = dly_active_reg && (dly_cnt_reg == delay_reg);
	wire pwm_start = use_delay ? dly_hit : pwm_edge;
	wire sw_start = !tsrc_reg && start_prev_reg && !start_reg;
	wire trig = tsrc_reg ? pwm_start : sw_start;
	wire conv_start = trig && power_reg && (state_reg == ST_IDLE);

	// A/D clock ticks every 2^n system clocks.
	wire [6:0] presc_mask = PRESC_ONES >> (3'h7 - div_reg);
	wire adc_tick = (presc_reg & presc_mask) == presc_mask;
	wire conv_end = (state_reg == ST_CONVERT) && adc_tick &&
		(tick_cnt_reg == TOTAL_TICKS - 5'h01);
	wire below_low = RESULT_I <= low_bound_reg;
	wire above_high = RESULT_I >= high_bound_reg;
	logic cmp_hit;

	always_comb
	begin
		case (ctrl2_reg.compare_condition_select)
			CMP_INSIDE: cmp_hit = !below_low && !above_high;
			CMP_AT_LOW: cmp_hit = below_low;
			CMP_AT_HIGH: cmp_hit = above_high;
			default: cmp_hit = below_low || above_high;
		endcase
	end

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
				if (conv_start)
					state_next = ST_SAMPLE;
			ST_SAMPLE:
				if (!power_reg)
					state_next = ST_IDLE;
				else if (adc_tick && tick_cnt_reg == 5'(SAMPLE_TICKS) - 5'h01)
					state_next = ST_CONVERT;
			default:
				if (!power_reg || conv_end)
					state_next = ST_IDLE;
		endcase
	end

	wire done_next = conv_end || (done_flag_reg && !(wr_flags && PWDATA_I[DONE_BIT]));
	wire cmp_next = (conv_end && cmp_hit) ||
		(cmp_flag_reg && !(wr_flags && PWDATA_I[CMP_BIT]));

	// APB answer: one wait state, data and error from flip-flops.
	always_ff @(posedge CLOCK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end
		else
		begin
			pready_reg <= access && !pready_reg;
			pslverr_reg <= access && !pready_reg && !addr_ok;
			prdata_reg <= (access && !pready_reg && !PWRITE_I) ? {24'h000000, rd_byte} :
				32'h0000_0000;
		end
	end

	// Software registers. Power-off leaves the boundary values alone.
	always_ff @(posedge CLOCK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			start_reg <= 1'b0;
			power_reg <= 1'b0;
			tsrc_reg <= 1'b0;
			fmt_reg <= 1'b0;
			div_reg <= DIV_RST;
			ctrl2_reg <= CTRL2_RST;
			delay_reg <= DELAY_RST;
			low_bound_reg <= BOUND_RST;
			high_bound_reg <= BOUND_RST;
			irq_en_reg <= 2'h0;
		end
		else
		begin
			if (wr_ctrl0)
			begin
				start_reg <= PWDATA_I[START_BIT];
				power_reg <= PWDATA_I[PWR_BIT];
				tsrc_reg <= PWDATA_I[TSRC_BIT];
				fmt_reg <= PWDATA_I[FMT_BIT];
			end
			if (wr_ctrl1)
				div_reg <= PWDATA_I[2:0];
			if (wr_ctrl2)
				ctrl2_reg <= {PWDATA_I[6:3], 1'b0, PWDATA_I[1:0]};
			if (wr_delay)
				delay_reg <= PWDATA_I[7:0];
			if (wr_lb_hi || wr_lb_lo)
				low_bound_reg <= byte_merge(low_bound_reg, fmt_reg, wr_lb_hi,
					PWDATA_I[7:0]);
			if (wr_hb_hi || wr_hb_lo)
				high_bound_reg <= byte_merge(high_bound_reg, fmt_reg, wr_hb_hi,
					PWDATA_I[7:0]);
			if (wr_irq_en)
				irq_en_reg <= PWDATA_I[1:0];
		end
	end

	// Conversion sequencing, delay counting and flags.
	always_ff @(posedge CLOCK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			start_prev_reg <= 1'b0;
			pwm_prev_reg <= 1'b0;
			dly_active_reg <= 1'b0;
			dly_cnt_reg <= DELAY_RST;
			presc_reg <= 7'h00;
			tick_cnt_reg <= 5'h00;
			state_reg <= ST_IDLE;
			busy_reg <= 1'b0;
			sample_reg <= 1'b0;
			result_reg <= BOUND_RST;
			done_flag_reg <= 1'b0;
			cmp_flag_reg <= 1'b0;
			adc_irq_reg <= 1'b0;
			cmp_irq_reg <= 1'b0;
		end
		else
		begin
			start_prev_reg <= start_reg;
			pwm_prev_reg <= pwm_flag;
			if (pwm_edge && use_delay)
			begin
				dly_active_reg <= 1'b1;
				dly_cnt_reg <= 8'h01;
			end
			else if (dly_hit || !use_delay)
				dly_active_reg <= 1'b0;
			else if (dly_active_reg)
				dly_cnt_reg <= dly_cnt_reg + 8'h01;
			presc_reg <= conv_start ? 7'h00 : presc_reg + 7'h01;
			if (conv_start)
				tick_cnt_reg <= 5'h00;
			else if (state_reg != ST_IDLE && adc_tick)
				tick_cnt_reg <= tick_cnt_reg + 5'h01;
			state_reg <= state_next;
			busy_reg <= state_next != ST_IDLE;
			sample_reg <= state_next == ST_SAMPLE;
			if (conv_end)
				result_reg <= RESULT_I;
			done_flag_reg <= done_next;
			cmp_flag_reg <= cmp_next;
			adc_irq_reg <= done_next && irq_en_reg[DONE_BIT];
			cmp_irq_reg <= cmp_next && irq_en_reg[CMP_BIT];
		end
	end

	assign PRDATA_O = prdata_reg;
	assign PREADY_O = pready_reg;
	assign PSLVERR_O = pslverr_reg;
	assign POWER_EN_O = power_reg;
	assign SAMPLE_O = sample_reg;
	assign BUSY_O = busy_reg;
	assign ADC_IRQ_O = adc_irq_reg;
	assign CMP_IRQ_O = cmp_irq_reg;

	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RST_N_I);

	sequence busy_sixteen_s;
		busy_reg [*8] ##1 busy_reg [*8] ##1 !busy_reg;
	endsequence

	duty_chan_two_a: assert property (tsrc_reg && ctrl2_reg.pwm_event_select
		&& ctrl2_reg.duty_source_select[1] && !use_delay && $rose(PWM_DUTY_FLAG_I[2])
		&& !pwm_prev_reg && power_reg && state_reg == ST_IDLE |=> busy_reg)
		else $error("duty channel two did not start a conversion");
	ctrl2_bit_zero_a: assert property (access && !pready_reg && !PWRITE_I
		&& PADDR_I == OFF_CTRL2 |=> !PRDATA_O[2])
		else $error("control register 2 bit 2 read as one");
	delay_start_a: assert property (pwm_edge && use_delay && delay_reg == 8'h05
		&& !wr && power_reg && state_reg == ST_IDLE |=> (!busy_reg) [*5] ##1 busy_reg)
		else $error("delayed start not five clocks after the flag edge");
	no_delay_a: assert property (pwm_edge && !ctrl2_reg.delay_enable && power_reg
		&& state_reg == ST_IDLE |=> busy_reg)
		else $error("undelayed trigger did not start at once");
	sw_pulse_a: assert property (!tsrc_reg && $fell(start_reg) && power_reg
		&& state_reg == ST_IDLE |=> busy_reg)
		else $error("software start pulse ignored");
	busy_length_a: assert property (conv_start && div_reg == 3'h0 && !wr_ctrl1
		&& !wr_ctrl0 |=> busy_sixteen_s)
		else $error("busy not held for sixteen A/D clocks");
	sample_four_a: assert property (conv_start && div_reg == 3'h0 && !wr_ctrl0
		|=> sample_reg [*4] ##1 !sample_reg && busy_reg)
		else $error("sampling phase not four A/D clocks");
	done_flag_a: assert property (conv_end |=> done_flag_reg && !busy_reg
		##0 (ADC_IRQ_O == $past(irq_en_reg[DONE_BIT])))
		else $error("completion flag or interrupt wrong");
	irq_gate_a: assert property (!irq_en_reg[DONE_BIT] && !wr_irq_en |=> !ADC_IRQ_O)
		else $error("interrupt forwarded while disabled");
	cmp_cond_a: assert property (conv_end
		&& ctrl2_reg.compare_condition_select == CMP_AT_LOW && RESULT_I <= low_bound_reg
		|=> cmp_flag_reg)
		else $error("at-or-below-low compare not flagged");
endmodule : ats_trigger_sequencer
